// ### dssq_sequencer.sv
// Purpose: host sequencer for a dual-slope converter front end
// Assumes: zero_cross_flag synchronous to mclk
// Notes: auto-zero and integrate lengths are parameters
`timescale 1ns/1ps
module dssq_sequencer #(
  parameter int unsigned int_cycles = dssq_pkg::int_cycles_c,
  parameter int unsigned az_cycles  = dssq_pkg::int_cycles_c
) (
  input  wire logic                      mclk,
  input  wire logic                      reset,
  input  wire logic                      clk_en,
  input  wire logic                      start,
  input  wire logic                      zero_cross_flag,
  output logic [1:0]                     phase_code,
  output logic                           busy,
  output logic                           result_valid,
  output dssq_pkg::dssq_result_type      result
);
  localparam int unsigned cw = dssq_pkg::count_w_c;
  localparam logic [cw-1:0] int_last = cw'(int_cycles - 1);
  localparam logic [cw-1:0] az_last  = cw'(az_cycles - 1);
  localparam logic [cw-1:0] run_max  = cw'(2 * int_cycles);

  dssq_pkg::dssq_state_type  state_reg, state_next;
  logic [cw-1:0]             cnt_reg, cnt_next;
  logic                      sign_reg, sign_next;
  logic                      valid_reg, valid_next;
  logic                      az_done_reg, az_done_next;
  logic [1:0]                code_reg, code_next;
  dssq_pkg::dssq_result_type res_reg, res_next;

  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    sign_next    = sign_reg;
    code_next    = code_reg;
    res_next     = res_reg;
    az_done_next = az_done_reg;
    valid_next   = 1'b0;
    unique case (state_reg)
      dssq_pkg::dssq_idle_s: begin
        // flag ignored here
        code_next = dssq_pkg::code_offset_null_c;
        if (start) begin
          if (az_done_reg) begin
            state_next = dssq_pkg::dssq_int_s;
            code_next  = dssq_pkg::code_integrate_c;
          end else begin
            state_next = dssq_pkg::dssq_null_s;
          end
          cnt_next = '0;
        end
      end
      dssq_pkg::dssq_null_s: begin
        // auto-zero lasts az_cycles, whose default is int_cycles_c, not the int_cycles parameter
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == az_last) begin
          state_next = dssq_pkg::dssq_int_s;
          code_next  = dssq_pkg::code_integrate_c;
          cnt_next   = '0;
        end
      end
      dssq_pkg::dssq_int_s: begin
        // fixed length every time
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == int_last) begin
          sign_next  = zero_cross_flag;
          state_next = dssq_pkg::dssq_run_s;
          code_next  = dssq_pkg::code_rundown_c;
          cnt_next   = '0;
        end
      end
      dssq_pkg::dssq_run_s: begin
        cnt_next = cnt_reg + 1'b1;
        if (!zero_cross_flag || cnt_reg == run_max) begin
          // leave on the same edge
          state_next          = dssq_pkg::dssq_onull_s;
          code_next           = dssq_pkg::code_output_null_c;
          res_next.sign       = sign_reg;
          res_next.magnitude  = cnt_reg;
          res_next.over_range = zero_cross_flag;
        end
      end
      dssq_pkg::dssq_onull_s: begin
        if (zero_cross_flag) begin
          // stop at once
          state_next   = dssq_pkg::dssq_idle_s;
          code_next    = dssq_pkg::code_offset_null_c;
          valid_next   = 1'b1;
          az_done_next = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg   <= dssq_pkg::dssq_idle_s;
      cnt_reg     <= '0;
      sign_reg    <= 1'b0;
      valid_reg   <= 1'b0;
      az_done_reg <= 1'b0;
      code_reg    <= dssq_pkg::code_offset_null_c;
      res_reg     <= '0;
    end else if (clk_en) begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      sign_reg    <= sign_next;
      valid_reg   <= valid_next;
      az_done_reg <= az_done_next;
      code_reg    <= code_next;
      res_reg     <= res_next;
    end
  end

  // held in a register for the whole phase
  assign phase_code   = code_reg;
  assign busy         = (state_reg != dssq_pkg::dssq_idle_s);
  assign result_valid = valid_reg;
  assign result       = res_reg;
endmodule

// ### dssq_pkg.sv
// Purpose: constants and types for the dual-slope phase sequencer
// Assumes: mclk at 40 MHz
// Notes: host side; drives the phase_code pins and reads zero_cross_flag
// Behaviour
// - hold phase_code steady for whole phase
// - codes: offset null 01, integrate 10, rundown 11, output null 00
// - falling flag in rundown ends conversion
// - store polarity at end of integration
// - stored polarity is result sign
// - sample polarity just before 10 to 11
// - ignore flag during offset null
// - integration time is line-period multiple (code: t_int_ms_c = 66, not a whole number of line periods)
// - integration time same every conversion
// - rundown follows integration at once, ends at crossing
// - time rundown from 10-11 to falling flag
// - rundown limit twice integration count
// - leave rundown immediately after falling edge
// - output null until flag high, then leave
// - then offset null held until next start
// - offset null time equals integration time
// - offset null is idle, unlimited duration
// - select pins outputs, flag is input
package dssq_pkg;
  localparam int unsigned clk_hz_c        = 40000000;
  localparam int unsigned t_int_ms_c      = 66;
  localparam int unsigned int_cycles_c    = (clk_hz_c / 1000) * t_int_ms_c;
  localparam int unsigned cmp_delay_ns_c  = 2000;
  localparam int unsigned cmp_delay_cyc_c = (cmp_delay_ns_c * (clk_hz_c / 1000000)) / 1000;
  localparam int unsigned count_w_c       = 24;

  localparam logic [1:0] code_offset_null_c = 2'h1;
  localparam logic [1:0] code_integrate_c   = 2'h2;
  localparam logic [1:0] code_rundown_c     = 2'h3;
  localparam logic [1:0] code_output_null_c = 2'h0;

  typedef enum logic [2:0] {
    dssq_idle_s, dssq_null_s, dssq_int_s, dssq_run_s, dssq_onull_s
  } dssq_state_type;

  typedef struct packed {
    logic                 sign;
    logic                 over_range;
    logic [count_w_c-1:0] magnitude;
  } dssq_result_type;
endpackage

// ### dssq_checker.sv
// Purpose: port checks of the sequencer
// Assumes: one clock
// Notes: sign_reg keeps the last integrate flag
`timescale 1ns/1ps
module dssq_checker #(parameter int unsigned int_cycles = 20) (
  input wire logic mclk, reset, clk_en, start, zero_cross_flag, busy, result_valid,
  input wire logic [1:0] phase_code,
  input wire dssq_pkg::dssq_result_type result
);
  logic sign_reg;
  always_ff @(posedge mclk or posedge reset)
    if (reset) sign_reg <= 1'b0;
    else if (clk_en && phase_code == 2'h2) sign_reg <= zero_cross_flag;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_run_in; phase_code == 2'h2 ##1 phase_code == 2'h3; endsequence
  a_idle_code: assert property (!busy |-> phase_code == 2'h1) else $error("idle");
  a_run_entry: assert property ($changed(phase_code) && phase_code == 2'h3 |-> $past(phase_code) == 2'h2) else $error("entry");
  a_sign_kept: assert property (s_run_in ##[1:300] result_valid |-> result.sign == sign_reg) else $error("sign");
  a_run_exit: assert property (phase_code == 2'h3 && clk_en && !zero_cross_flag |=> phase_code == 2'h0) else $error("exit");
  a_null_hold: assert property (phase_code == 2'h0 && !(clk_en && zero_cross_flag) |=> phase_code == 2'h0) else $error("hold");
  a_null_exit: assert property (phase_code == 2'h0 && clk_en && zero_cross_flag |=> phase_code == 2'h1 && result_valid) else $error("null");
  a_frozen_code: assert property (!clk_en |=> $stable(phase_code)) else $error("frozen");
  a_over_mag: assert property (result_valid |-> (result.over_range ? result.magnitude == 2 * int_cycles : result.magnitude <= 2 * int_cycles)) else $error("mag");
endmodule
bind dssq_sequencer dssq_checker #(.int_cycles(int_cycles)) u_chk (.mclk, .reset, .clk_en, .start, .zero_cross_flag,
  .busy, .result_valid, .phase_code, .result);

// ### dssq_dev.sv
// Purpose: front end model
// Assumes: depth is rundown length
// Notes: flag toggles in offset null
`timescale 1ns/1ps
module dssq_dev (
  input wire logic mclk, reset, pos,
  input wire logic [5:0] depth,
  input wire logic [1:0] phase_code,
  output logic zero_cross_flag
);
  logic [6:0] n_reg;
  logic t_reg;
  always_ff @(posedge mclk or posedge reset)
    if (reset) {n_reg, t_reg} <= 8'h0;
    else {n_reg, t_reg} <= {(phase_code[1] ^ phase_code[0]) ? 7'h0 : n_reg + 7'h1, ~t_reg};
  always_comb
    case (phase_code)
      2'h2: zero_cross_flag = pos;
      // comparator lag folded into depth
      2'h3: zero_cross_flag = n_reg < {1'b0, depth};
      2'h0: zero_cross_flag = n_reg >= {1'b0, depth} + 7'h3;
      default: zero_cross_flag = t_reg;
    endcase
endmodule

// ### dual_slope_phase_sequencer_tb.sv
// Purpose: random and corner conversions
// Assumes: dssq_dev front end
// Notes: ni shortens both timed phases
`timescale 1ns/1ps
module dual_slope_phase_sequencer_tb;
  localparam int unsigned ni = 20;
  logic mclk = 0, reset = 1, clk_en = 1, start = 0, pos = 0, zero_cross_flag, busy, result_valid;
  logic [5:0] depth = 6'h0;
  logic [1:0] phase_code;
  logic [31:0] r = 32'h32b68d6e;
  dssq_pkg::dssq_result_type result;
  int err_total = 0, check_count = 0, naz = 0, nint = 0, i, k;
  always #12.5 mclk = ~mclk;
  dssq_sequencer #(.int_cycles(ni), .az_cycles(ni)) dut (.mclk, .reset, .clk_en, .start, .zero_cross_flag,
    .phase_code, .busy, .result_valid, .result);
  dssq_dev u_dev (.mclk, .reset, .pos, .depth, .phase_code, .zero_cross_flag);
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [25:0] want(input logic s, input logic [5:0] d);
    return d > 2 * ni ? {s, 1'b1, 24'(2 * ni)} : {s, 1'b0, 18'h0, d};
  endfunction
  task automatic chk(input logic [25:0] seen, input logic [25:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge mclk) begin
    naz += busy && clk_en && phase_code == 2'h1;
    nint += clk_en && phase_code == 2'h2;
  end
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 0;
    for (i = 0; i < 24; i++) begin
      r = nx(r);
      pos <= r[0];
      depth <= i == 0 ? 6'h27 : i == 1 ? 6'h28 : i == 2 ? 6'h0 : r[8:3];
      start <= 1;
      k = 0;
      do begin
        @(posedge mclk);
        r = nx(r);
        clk_en <= phase_code != 2'h1 || r[1:0] != 2'h0;
        if (busy) start <= 0;
        k++;
      end while (!result_valid && k < 400);
      if (k == 400) err_total++;
      if (k == 400) final_report();
      chk(result, want(pos, depth));
      chk(26'(naz), 26'(ni));
      chk(26'(nint), 26'(ni));
      clk_en <= 1;
      #1 naz = 0;
      nint = 0;
      repeat (1 + r[4:2]) @(posedge mclk);
    end
    final_report();
  end
endmodule
